// ### pcsd_decode.sv
// port config space decoder: address forming, port select, undefined policy
// Operation
// - every register belongs to one port space
// - system address is port base plus offset
// - eeprom and smbus accesses use system address
// - upstream port 0 based at 0x0000
// - downstream port 2 based at 0x2000
// - downstream port 4 based at 0x4000
// - global and test registers upstream only
// - msi capability downstream only
// - config read of undefined offset returns zero
// - smbus undefined read data is arbitrary
// - undefined writes complete, change nothing
`timescale 1ns/10ps
`default_nettype none
`include "pcsd_consts.svh"

module pcsd_decode
    import pcsd_pkg::*;
#(
    parameter logic [31:0] IMPL_MASK_UP = 32'hFFFF_FFFF,
    parameter logic [31:0] IMPL_MASK_DN = 32'h0000_FFFF
)
(
    // clock and reset
    input  wire logic        CLK_SYS,
    input  wire logic        RESET,
    // access request
    input  wire pcsd_req_t   REQ,
    // register storage side
    output pcsd_dec_t        DEC,
    output logic [15:0]      SYS_ADDR,
    input  wire logic [31:0] STORE_RDATA,
    // completion
    output pcsd_cpl_t        CPL
);

    // ==============================================================
    // port base lookup, used for forming the system address
    function automatic logic [15:0] port_base(input pcsd_port_t p);
        logic [15:0] b;
        b = `PCSD_BASE_P0;
        unique case (p)
            PCSD_PORT_UP:   b = `PCSD_BASE_P0;
            PCSD_PORT_DN_A: b = `PCSD_BASE_P2;
            PCSD_PORT_DN_B: b = `PCSD_BASE_P4;
            PCSD_PORT_NONE: b = `PCSD_BASE_P0;
        endcase
        return b;
    endfunction

    // upper bits pick the owning port
    function automatic pcsd_port_t port_of(input logic [15:0] a);
        pcsd_port_t p;
        p = PCSD_PORT_NONE;
        unique case (a[`PCSD_SEL_MSB:`PCSD_SEL_LSB])
            `PCSD_SEL_P0: p = PCSD_PORT_UP;
            `PCSD_SEL_P2: p = PCSD_PORT_DN_A;
            `PCSD_SEL_P4: p = PCSD_PORT_DN_B;
            default:      p = PCSD_PORT_NONE;
        endcase
        return p;
    endfunction

    // ==============================================================
    // combinational decode of the current request
    pcsd_port_t  cur_port;
    logic [15:0] cur_sys;
    logic [12:0] cur_ofs;
    logic        ofs_wide;
    logic        cur_def;

    always_comb
    begin
        cur_port = PCSD_PORT_NONE;
        cur_sys  = REQ.addr;
        ofs_wide = 1'b0;
        if (REQ.src == PCSD_SRC_CFG)
        begin
            // config requests arrive with port and bare offset
            cur_port = pcsd_port_t'(REQ.port_idx);
            ofs_wide = REQ.addr[`PCSD_SEL_MSB:`PCSD_OFS_W] != '0;
            cur_sys  = port_base(cur_port) + REQ.addr;
        end
        else
        begin
            // eeprom and smbus already speak system addresses
            cur_port = port_of(REQ.addr);
        end
        cur_ofs = cur_sys[`PCSD_OFS_W-1:0];
    end

    pcsd_map u_map
    (
        .port         (cur_port),
        .offset       (cur_ofs),
        .impl_mask_up (IMPL_MASK_UP),
        .impl_mask_dn (IMPL_MASK_DN),
        .defined      (cur_def)
    );

    logic hit;
    assign hit = cur_def && !ofs_wide && (cur_port != PCSD_PORT_NONE);

    // ==============================================================
    // request forwarded to storage: only defined locations see strobes
    pcsd_dec_t   dec_reg;
    logic [15:0] sys_reg;

    always_ff @(posedge CLK_SYS)
    begin
        if (RESET)
        begin
            dec_reg <= '0;
            sys_reg <= `PCSD_BASE_P0;
        end
        else
        begin
            dec_reg.valid  <= REQ.valid && hit;
            dec_reg.write  <= REQ.write;
            dec_reg.port   <= cur_port;
            dec_reg.offset <= cur_ofs;
            dec_reg.be     <= REQ.be;
            dec_reg.wdata  <= REQ.wdata;
            sys_reg        <= cur_sys;
        end
    end

    assign DEC      = dec_reg;
    assign SYS_ADDR = sys_reg;

    // ==============================================================
    // completion stage one cycle after forward; read data from storage
    logic       pend_reg;
    logic       pend_def_reg;
    logic       pend_wr_reg;
    pcsd_src_t  pend_src_reg;

    always_ff @(posedge CLK_SYS)
    begin
        if (RESET)
        begin
            pend_reg     <= 1'b0;
            pend_def_reg <= 1'b0;
            pend_wr_reg  <= 1'b0;
            pend_src_reg <= PCSD_SRC_CFG;
        end
        else
        begin
            pend_reg     <= REQ.valid;
            pend_def_reg <= hit;
            pend_wr_reg  <= REQ.write;
            pend_src_reg <= REQ.src;
        end
    end

    // completion data chosen by origin when offset is undefined
    pcsd_cpl_t cpl_reg;

    always_ff @(posedge CLK_SYS)
    begin
        if (RESET)
        begin
            cpl_reg <= '0;
        end
        else
        begin
            cpl_reg.valid   <= pend_reg;         // writes always complete
            cpl_reg.defined <= pend_def_reg;
            if (!pend_reg || pend_wr_reg)
                cpl_reg.rdata <= `PCSD_ZERO_DATA;
            else if (pend_def_reg)
                cpl_reg.rdata <= STORE_RDATA;
            else if (pend_src_reg == PCSD_SRC_CFG)
                cpl_reg.rdata <= `PCSD_ZERO_DATA;
            else
                cpl_reg.rdata <= `PCSD_ALL_ONES;
        end
    end

    assign CPL = cpl_reg;

endmodule
`default_nettype wire

// ### pcsd_consts.svh
// constants for the port configuration space decoder
`ifndef PCSD_CONSTS_SVH
`define PCSD_CONSTS_SVH

// port base addresses in the system map
`define PCSD_BASE_P0      16'h0000
`define PCSD_BASE_P2      16'h2000
`define PCSD_BASE_P4      16'h4000
// port select lives in system address bits 15:13
`define PCSD_SEL_MSB      15
`define PCSD_SEL_LSB      13
`define PCSD_SEL_P0       3'h0
`define PCSD_SEL_P2       3'h1
`define PCSD_SEL_P4       3'h2
// offset field width within a port space
`define PCSD_OFS_W        13
// 128-byte register group index inside an offset
`define PCSD_GRP_MSB      11
`define PCSD_GRP_LSB      7
// region boundaries inside a port space (byte offsets)
`define PCSD_STD_LAST     13'h0FFF
`define PCSD_GLOBAL_FIRST 13'h0400
`define PCSD_GLOBAL_LAST  13'h07FF
`define PCSD_MSI_FIRST    13'h00D0
`define PCSD_MSI_LAST     13'h00DC
`define PCSD_ZERO_DATA    32'h0000_0000
`define PCSD_ALL_ONES     32'hFFFF_FFFF

`endif

// ### pcsd_pkg.sv
// types shared by the port configuration space decoder
package pcsd_pkg;

    // which port owns an access
    typedef enum logic [1:0]
    {
        PCSD_PORT_UP,
        PCSD_PORT_DN_A,
        PCSD_PORT_DN_B,
        PCSD_PORT_NONE
    } pcsd_port_t;

    // origin of an access
    typedef enum logic [1:0]
    {
        PCSD_SRC_CFG,
        PCSD_SRC_EEPROM,
        PCSD_SRC_SMBUS
    } pcsd_src_t;

    // incoming register access
    typedef struct packed
    {
        logic        valid;
        logic        write;
        pcsd_src_t   src;
        logic [1:0]  port_idx;   // config requests name a port directly
        logic [15:0] addr;       // offset for config, system addr otherwise
        logic [3:0]  be;
        logic [31:0] wdata;
    } pcsd_req_t;

    // decoded access sent toward the register storage
    typedef struct packed
    {
        logic        valid;
        logic        write;
        pcsd_port_t  port;
        logic [12:0] offset;
        logic [3:0]  be;
        logic [31:0] wdata;
    } pcsd_dec_t;

    // completion returned to the requester
    typedef struct packed
    {
        logic        valid;
        logic        defined;
        logic [31:0] rdata;
    } pcsd_cpl_t;

endpackage

// ### pcsd_map.sv
// combinational region map: is an offset defined for a given port
`timescale 1ns/10ps
`default_nettype none
`include "pcsd_consts.svh"

module pcsd_map
    import pcsd_pkg::*;
(
    // decoded location
    input  wire pcsd_port_t  port,
    input  wire logic [12:0] offset,
    input  wire logic [31:0] impl_mask_up,
    input  wire logic [31:0] impl_mask_dn,
    // verdict
    output logic             defined
);

    // ==============================================================
    // region classification
    logic in_std;
    logic in_global;
    logic in_msi;
    logic grp_ok;

    always_comb
    begin
        in_std    = offset <= `PCSD_STD_LAST;
        in_global = (offset >= `PCSD_GLOBAL_FIRST) &&
                    (offset <= `PCSD_GLOBAL_LAST);
        in_msi    = (offset >= `PCSD_MSI_FIRST) &&
                    (offset <= `PCSD_MSI_LAST);
        // implementation masks mark which 128-byte groups hold registers
        grp_ok    = 1'b0;
        unique case (port)
            PCSD_PORT_UP:
                grp_ok = impl_mask_up[offset[`PCSD_GRP_MSB:`PCSD_GRP_LSB]]
                         && !in_msi;
            PCSD_PORT_DN_A, PCSD_PORT_DN_B:
                grp_ok = (impl_mask_dn[offset[`PCSD_GRP_MSB:`PCSD_GRP_LSB]]
                          || in_msi)
                         && !in_global;
            PCSD_PORT_NONE:
                grp_ok = 1'b0;
        endcase
        defined = in_std && grp_ok;
    end

endmodule
`default_nettype wire

// ### pcsd_decode_asserts.sv
// checker for the config space decoder ports
`timescale 1ns/10ps
`default_nettype none
// ==========
// checker
module pcsd_decode_chk
    import pcsd_pkg::*;
(
    // clock and reset
    input wire logic        CLK_SYS,
    input wire logic        RESET,
    // watched ports
    input wire pcsd_req_t   REQ,
    input wire pcsd_dec_t   DEC,
    input wire logic [15:0] SYS_ADDR,
    input wire logic [31:0] STORE_RDATA,
    input wire pcsd_cpl_t   CPL
);
    default clocking @(posedge CLK_SYS);
    endclocking
    default disable iff (RESET);
    // shorthands for the request being taken
    wire logic       rq  = REQ.valid;
    wire logic       sys = REQ.src != PCSD_SRC_CFG;
    wire logic [2:0] sel = REQ.addr[15:13];
    wire logic [12:0] ofs = REQ.addr[12:0];

    chk_cpl_fixed: assert property (
        rq |-> ##2 CPL.valid) else $error("completion late");
    chk_cfg_base: assert property (
        rq && !sys && REQ.port_idx < 2'h3 && REQ.addr < 16'h2000 |=>
        SYS_ADDR == {1'b0, $past(REQ.port_idx), 13'h0} + $past(REQ.addr))
        else $error("bad system address");
    chk_sys_pass: assert property (
        rq && sys |=> SYS_ADDR == $past(REQ.addr))
        else $error("system address altered");
    chk_sel_range: assert property (
        rq && sys && sel > 3'h2 |=> !DEC.valid)
        else $error("unmapped port decoded");
    chk_global_up: assert property (
        rq && sys && sel inside {3'h1, 3'h2} &&
        ofs inside {[13'h400:13'h7FF]} |=> !DEC.valid)
        else $error("global region downstream");
    chk_msi_dn: assert property (
        rq && sys && sel < 3'h3 && ofs inside {[13'h0D0:13'h0DC]} |=>
        DEC.valid == ($past(sel) != 3'h0)) else $error("msi side wrong");
    chk_cfg_zero: assert property (
        rq && !REQ.write && !sys ##2 CPL.valid && !CPL.defined |->
        CPL.rdata == 32'h0) else $error("undefined read not zero");
    chk_undef_quiet: assert property (
        rq && REQ.write ##2 !CPL.defined |-> !$past(DEC.valid))
        else $error("undefined write reached storage");
    chk_store_data: assert property (
        DEC.valid && !DEC.write |=> CPL.defined &&
        CPL.rdata == $past(STORE_RDATA)) else $error("read data lost");

    cover property (DEC.valid && DEC.write);
    cover property (CPL.valid && !CPL.defined);
    cover property (rq ##1 rq);
endmodule

bind pcsd_decode pcsd_decode_chk pcsd_decode_chk_inst (.CLK_SYS, .RESET,
    .REQ, .DEC, .SYS_ADDR, .STORE_RDATA, .CPL);
`default_nettype wire

// ### pcsd_store_model.sv
// register storage model behind the decoder
`timescale 1ns/10ps
`default_nettype none
// ==========
// storage
module pcsd_store_model
    import pcsd_pkg::*;
(
    // clock
    input  wire logic      clk,
    // decoded access and answer
    input  wire pcsd_dec_t dec,
    output logic [31:0]    rdata
);
    logic toggle_reg = 1'b0;
    // idle pattern moves each cycle so stale data never passes
    always_ff @(posedge clk)
        toggle_reg <= ~toggle_reg;
    // data names port and offset, so misrouting shows
    assign rdata = dec.valid ? {8'hA5, 6'h0, dec.port, 3'h0, dec.offset}
                             : {32{toggle_reg}};
endmodule
`default_nettype wire

// ### pcsd_decode_tb.sv
// self-checking bench for the config space decoder
`timescale 1ns/10ps
`default_nettype none
// ==========
// bench
module pcsd_decode_tb;
    import pcsd_pkg::*;
    typedef struct packed
    {
        pcsd_src_t   s;
        logic [1:0]  p;
        logic [15:0] a;
        logic        w;
        logic        d;
        logic [31:0] r;
    } pcsd_row_t;
    logic        clk_sys = 1'b0;
    logic        reset = 1'b1;
    pcsd_req_t   req = '0;
    pcsd_dec_t   dec;
    pcsd_cpl_t   cpl;
    logic [15:0] sys_addr;
    logic [31:0] store_rdata;
    int          n_fail = 0;
    int          checked = 0;
    int          cycles = 0;
    // source, port, address, write, defined, read data
    pcsd_row_t rows [15] = '{
        '{PCSD_SRC_CFG, 2'h0, 16'h0000, 1'b0, 1'b1, 32'hA500_0000},
        '{PCSD_SRC_CFG, 2'h1, 16'h0040, 1'b0, 1'b1, 32'hA501_0040},
        '{PCSD_SRC_CFG, 2'h2, 16'h0044, 1'b0, 1'b1, 32'hA502_0044},
        '{PCSD_SRC_EEPROM, 2'h0, 16'h2010, 1'b0, 1'b1, 32'hA501_0010},
        '{PCSD_SRC_SMBUS, 2'h0, 16'h4010, 1'b0, 1'b1, 32'hA502_0010},
        '{PCSD_SRC_SMBUS, 2'h0, 16'h0500, 1'b0, 1'b1, 32'hA500_0500},
        '{PCSD_SRC_SMBUS, 2'h0, 16'h2500, 1'b0, 1'b0, 32'hFFFF_FFFF},
        '{PCSD_SRC_CFG, 2'h0, 16'h00D0, 1'b0, 1'b0, 32'h0000_0000},
        '{PCSD_SRC_CFG, 2'h2, 16'h00DC, 1'b0, 1'b1, 32'hA502_00DC},
        '{PCSD_SRC_SMBUS, 2'h0, 16'h6000, 1'b0, 1'b0, 32'hFFFF_FFFF},
        '{PCSD_SRC_CFG, 2'h1, 16'h0800, 1'b1, 1'b0, 32'h0000_0000},
        '{PCSD_SRC_SMBUS, 2'h0, 16'h2040, 1'b1, 1'b1, 32'h0000_0000},
        '{PCSD_SRC_SMBUS, 2'h0, 16'h20D4, 1'b0, 1'b1, 32'hA501_00D4},
        '{PCSD_SRC_EEPROM, 2'h0, 16'h00D0, 1'b0, 1'b0, 32'hFFFF_FFFF},
        '{PCSD_SRC_CFG, 2'h0, 16'h2004, 1'b0, 1'b0, 32'h0000_0000}};

    pcsd_decode pcsd_decode_inst (.CLK_SYS(clk_sys), .RESET(reset),
        .REQ(req), .DEC(dec), .SYS_ADDR(sys_addr),
        .STORE_RDATA(store_rdata), .CPL(cpl));
    pcsd_store_model pcsd_store_model_inst (.clk(clk_sys), .dec(dec),
        .rdata(store_rdata));

    // ==========
    // clock, watchdog and helpers
    initial
    begin
        forever #20 clk_sys = ~clk_sys;
    end
    // run needs about 75 cycles, so 1000 means a hang
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 1000)
        begin
            n_fail++;
            finish_test();
        end
    end
    task automatic cmp(input string n, input logic [31:0] e, g);
        checked++;
        if (g !== e)
        begin
            n_fail++;
            $display("CHECK FAILED %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic send(input pcsd_row_t r);
        @(negedge clk_sys);
        req = '{1'b1, r.w, r.s, r.p, r.a, 4'hF, 32'hC3C3_3C3C};
    endtask
    task automatic exp_dec(input pcsd_row_t r);
        cmp("dec.valid", r.d, dec.valid);
        cmp("sys_addr", r.s == PCSD_SRC_CFG ? {1'b0, r.p, 13'h0} + r.a : r.a,
            sys_addr);
        if (r.d)
        begin
            // defined accesses carry the whole request to storage
            cmp("dec.write", r.w, dec.write);
            cmp("dec.be", 4'hF, dec.be);
            cmp("dec.wdata", 32'hC3C3_3C3C, dec.wdata);
        end
    endtask
    task automatic exp_cpl(input pcsd_row_t r);
        cmp("cpl.valid", 1, cpl.valid);
        cmp("cpl.defined", r.d, cpl.defined);
        // writes complete with zero data, undefined reads per origin
        cmp("cpl.rdata", r.r, cpl.rdata);
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // ==========
    // tests
    initial
    begin
        repeat (20) @(negedge clk_sys);
        cmp("cpl.valid", 0, cpl.valid);
        reset = 1'b0;
        for (int i = 0; i < 15; i++)
        begin
            send(rows[i]);
            @(negedge clk_sys);
            req.valid = 1'b0;
            exp_dec(rows[i]);
            @(negedge clk_sys);
            exp_cpl(rows[i]);
        end
        $display("test table done");
        // back to back: defined then unmapped; forward lags one cycle
        send(rows[3]);
        send(rows[9]);
        exp_dec(rows[3]);
        @(negedge clk_sys);
        req.valid = 1'b0;
        exp_cpl(rows[3]);
        exp_dec(rows[9]);
        @(negedge clk_sys);
        exp_cpl(rows[9]);
        $display("test back to back done");
        // reset in mid access drops it
        send(rows[1]);
        @(negedge clk_sys);
        req.valid = 1'b0;
        reset = 1'b1;
        @(negedge clk_sys);
        reset = 1'b0;
        cmp("cpl.valid", 0, cpl.valid);
        cmp("dec.valid", 0, dec.valid);
        send(rows[2]);
        @(negedge clk_sys);
        req.valid = 1'b0;
        exp_dec(rows[2]);
        @(negedge clk_sys);
        exp_cpl(rows[2]);
        $display("test reset done");
        finish_test();
    end
endmodule
`default_nettype wire
